/* pld_pkg.sv */
// Summary of operation
// - Management lamp: solid on link, blink on traffic
// - Management lamp dark without link or when disabled
// - Console lamp solid while console active
// - Copper gigabit: green 1000, amber 10/100
// - Copper ten-gigabit: green 10G, amber others
// - Optical gigabit: green 1000, amber 100
// - Optical ten-gigabit: green 10G, amber 1000
// - Any port lamp dark when link down
package pld_pkg;

  // Port population, in generate order: copper GE, copper XG, SFP, SFP+.
  localparam int NUM_GE    = 24;
  localparam int NUM_XG    = 2;
  localparam int NUM_SFP   = 2;
  localparam int NUM_SFPP  = 2;
  localparam int NUM_PORTS = NUM_GE + NUM_XG + NUM_SFP + NUM_SFPP;

  // Link speed code carried on each port's speed pins.
  localparam logic [1:0] SPEED_10M  = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G   = 2'h2;
  localparam logic [1:0] SPEED_10G  = 2'h3;

  // Colour masks, one bit per speed code.
  localparam logic [3:0] GE_GREEN   = 4'h4;
  localparam logic [3:0] GE_AMBER   = 4'h3;
  localparam logic [3:0] XG_GREEN   = 4'h8;
  localparam logic [3:0] XG_AMBER   = 4'h7;
  localparam logic [3:0] SFP_GREEN  = 4'h4;
  localparam logic [3:0] SFP_AMBER  = 4'h2;
  localparam logic [3:0] SFPP_GREEN = 4'h8;
  localparam logic [3:0] SFPP_AMBER = 4'h4;
  localparam logic [3:0] ANY_SPEED  = 4'hf;
  localparam logic [3:0] NO_SPEED   = 4'h0;

  // Register byte offsets.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_LINK   = 5'h04;
  localparam logic [4:0] REG_ACT    = 5'h08;
  localparam logic [4:0] REG_DEV    = 5'h0c;

  // Control fields and reset values.
  localparam int         CTRL_MANAGEMENT_PORT_INDICATOR_EN_BIT = 0;
  localparam int         CTRL_LEDS_EN_BIT = 1;
  localparam logic       MANAGEMENT_PORT_INDICATOR_EN_RST      = 1'b1;
  localparam logic       LEDS_EN_RST      = 1'b1;

  // Device status fields.
  localparam int DEV_MANAGEMENT_PORT_INDICATOR_LED_BIT = 0;
  localparam int DEV_CONS_LED_BIT = 1;
  localparam int DEV_MANAGEMENT_PORT_INDICATOR_LNK_BIT = 2;
  localparam int DEV_BLINK_BIT    = 3;

  // Timing.
  localparam int CLK_MHZ           = 250;
  localparam int BLINK_HALF_MS     = 100;
  localparam int STRETCH_MS        = 50;
  localparam int BLINK_HALF_CYC    = BLINK_HALF_MS * CLK_MHZ * 1000;
  localparam int STRETCH_CYC       = STRETCH_MS * CLK_MHZ * 1000;
  localparam logic [1:0] HOLD_TICKS = 2'h2;

endpackage

/* pld_time_if.sv */
interface pld_time_if;
  logic blink_phase;
  logic stretch_tick;
  modport src (output blink_phase, output stretch_tick);
  modport snk (input blink_phase, input stretch_tick);
endinterface

/* pld_led_chan.sv */
module pld_led_chan #(
  parameter logic [3:0] GREEN_MASK = 4'h4,
  parameter logic [3:0] AMBER_MASK = 4'h3
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Shared timebase
  pld_time_if.snk         tb,
  // Port status, asynchronous
  input  wire logic       link_in,
  input  wire logic       act_in,
  input  wire logic [1:0] speed_in,
  // Same-domain enable
  input  wire logic       allow,
  // Lamp drive and status
  output logic            green,
  output logic            amber,
  output logic            link_seen,
  output logic            act_held
);
  import pld_pkg::*;

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [1:0] hold_q;
  logic       lit;

  // Speed bits are synchronised apart; a speed change may show one odd cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {link_in, act_in, speed_in};
      sync_q <= meta_q;
    end
  end

  // A single frame reloads the hold, so it lasts at least one tick period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 2'h0;
    end else if (sync_q[2]) begin
      hold_q <= HOLD_TICKS;
    end else if (tb.stretch_tick && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end

  assign act_held  = hold_q != 2'h0;
  assign link_seen = sync_q[3];
  assign lit       = allow && sync_q[3] && (!act_held || tb.blink_phase);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      green <= 1'b0;
      amber <= 1'b0;
    end else begin
      green <= lit && GREEN_MASK[sync_q[1:0]];
      amber <= lit && AMBER_MASK[sync_q[1:0]] && !GREEN_MASK[sync_q[1:0]];
    end
  end

  dark_nolink_a: assert property (@(posedge clk) disable iff (!rst_b)
    !sync_q[3] |=> !green && !amber)
    else $error("port lamp lit without link");
  one_colour_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(green && amber))
    else $error("port lamp shows both colours");
  colour_speed_a: assert property (@(posedge clk) disable iff (!rst_b)
    green |-> GREEN_MASK[$past(sync_q[1:0])])
    else $error("green shown at wrong speed");
  idle_solid_a: assert property (@(posedge clk) disable iff (!rst_b)
    allow && sync_q[3] && !act_held && AMBER_MASK[sync_q[1:0]] && !GREEN_MASK[sync_q[1:0]]
    |=> amber)
    else $error("idle amber link not solid");
  stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    sync_q[2] |=> hold_q == HOLD_TICKS)
    else $error("activity not stretched");
endmodule

/* pld_panel_led.sv */
// Added by the designer: the placing of the registers and register access over Avalon-MM.
module pld_panel_led
  import pld_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = pld_pkg::BLINK_HALF_CYC,
  parameter int unsigned STRETCH_CYCLES    = pld_pkg::STRETCH_CYC
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]                       avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [31:0]                      avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic [31:0]                           avs_readdata,
  output logic                                  avs_waitrequest,
  // Per-port status, asynchronous
  input  wire logic [pld_pkg::NUM_PORTS-1:0]    port_link,
  input  wire logic [pld_pkg::NUM_PORTS-1:0]    port_act,
  input  wire logic [2*pld_pkg::NUM_PORTS-1:0]  port_speed,
  // Device status, asynchronous
  input  wire logic                             management_port_indicator_link,
  input  wire logic                             management_port_indicator_act,
  input  wire logic                             console_active,
  // Lamps
  output logic [pld_pkg::NUM_PORTS-1:0]         port_led_green,
  output logic [pld_pkg::NUM_PORTS-1:0]         port_led_amber,
  output logic                                  management_port_indicator,
  output logic                                  console_led_green
);
  import pld_pkg::*;

  pld_time_if tb ();

  logic                 ack_q;
  logic                 req;
  logic                 done;
  logic [31:0]          rd_mux;
  logic [31:0]          readdata_q;
  logic                 management_port_indicator_en_q;
  logic                 leds_en_q;
  logic [31:0]          blink_cnt_q;
  logic                 blink_phase_q;
  logic [31:0]          stretch_cnt_q;
  logic                 stretch_tick_q;
  logic                 cons_meta_q;
  logic                 cons_sync_q;
  logic                 console_q;
  logic [NUM_PORTS-1:0] link_seen;
  logic [NUM_PORTS-1:0] act_held;
  logic                 management_port_indicator_link_seen;
  logic                 management_port_indicator_act_held;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access completes.

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign done            = req && ack_q;
  assign avs_readdata    = readdata_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      REG_CTRL: begin
        rd_mux[CTRL_MANAGEMENT_PORT_INDICATOR_EN_BIT] = management_port_indicator_en_q;
        rd_mux[CTRL_LEDS_EN_BIT] = leds_en_q;
      end
      REG_LINK: rd_mux[NUM_PORTS-1:0] = link_seen;
      REG_ACT:  rd_mux[NUM_PORTS-1:0] = act_held;
      REG_DEV: begin
        rd_mux[DEV_MANAGEMENT_PORT_INDICATOR_LED_BIT] = management_port_indicator;
        rd_mux[DEV_CONS_LED_BIT] = console_led_green;
        rd_mux[DEV_MANAGEMENT_PORT_INDICATOR_LNK_BIT] = management_port_indicator_link_seen;
        rd_mux[DEV_BLINK_BIT]    = blink_phase_q;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data is captured in the wait cycle and stands at the completing edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_q <= 32'h0;
    end else if (avs_read && !ack_q) begin
      readdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      management_port_indicator_en_q <= MANAGEMENT_PORT_INDICATOR_EN_RST;
      leds_en_q <= LEDS_EN_RST;
    end else if (done && avs_write && avs_address == REG_CTRL && avs_byteenable[0]) begin
      management_port_indicator_en_q <= avs_writedata[CTRL_MANAGEMENT_PORT_INDICATOR_EN_BIT];
      leds_en_q <= avs_writedata[CTRL_LEDS_EN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timebase shared by the port and management lamps, so all blinking lamps stay in phase.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_q   <= 32'h0;
      blink_phase_q <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_q   <= 32'h0;
      blink_phase_q <= !blink_phase_q;
    end else begin
      blink_cnt_q   <= blink_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stretch_cnt_q  <= 32'h0;
      stretch_tick_q <= 1'b0;
    end else if (stretch_cnt_q == 32'(STRETCH_CYCLES - 1)) begin
      stretch_cnt_q  <= 32'h0;
      stretch_tick_q <= 1'b1;
    end else begin
      stretch_cnt_q  <= stretch_cnt_q + 32'h1;
      stretch_tick_q <= 1'b0;
    end
  end

  assign tb.blink_phase  = blink_phase_q;
  assign tb.stretch_tick = stretch_tick_q;

  //////////////////////////////////////////////////////////////////////////////
  // Port lamps.

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    localparam logic [3:0] GM = (i < NUM_GE) ? GE_GREEN :
                                (i < NUM_GE + NUM_XG) ? XG_GREEN :
                                (i < NUM_GE + NUM_XG + NUM_SFP) ? SFP_GREEN : SFPP_GREEN;
    localparam logic [3:0] AM = (i < NUM_GE) ? GE_AMBER :
                                (i < NUM_GE + NUM_XG) ? XG_AMBER :
                                (i < NUM_GE + NUM_XG + NUM_SFP) ? SFP_AMBER : SFPP_AMBER;
    pld_led_chan #(
      .GREEN_MASK (GM),
      .AMBER_MASK (AM)
    ) u_chan (
      .clk       (clk),
      .rst_b     (rst_b),
      .tb        (tb),
      .link_in   (port_link[i]),
      .act_in    (port_act[i]),
      .speed_in  (port_speed[2*i +: 2]),
      .allow     (leds_en_q),
      .green     (port_led_green[i]),
      .amber     (port_led_amber[i]),
      .link_seen (link_seen[i]),
      .act_held  (act_held[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Device lamps. The management lamp reuses a port channel that is green at
  // any speed; its speed pins are tied since that port has only one colour.

  pld_led_chan #(
    .GREEN_MASK (ANY_SPEED),
    .AMBER_MASK (NO_SPEED)
  ) u_management_port_indicator (
    .clk       (clk),
    .rst_b     (rst_b),
    .tb        (tb),
    .link_in   (management_port_indicator_link),
    .act_in    (management_port_indicator_act),
    .speed_in  (SPEED_10M),
    .allow     (leds_en_q && management_port_indicator_en_q),
    .green     (management_port_indicator),
    .amber     (),
    .link_seen (management_port_indicator_link_seen),
    .act_held  (management_port_indicator_act_held)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cons_meta_q <= 1'b0;
      cons_sync_q <= 1'b0;
      console_q   <= 1'b0;
    end else begin
      cons_meta_q <= console_active;
      cons_sync_q <= cons_meta_q;
      console_q   <= leds_en_q && cons_sync_q;
    end
  end

  assign console_led_green = console_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence bus_wait_s;
    req && avs_waitrequest;
  endsequence
  sequence bus_done_s;
    req && !avs_waitrequest;
  endsequence

  bus_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_wait_s ##1 req |-> bus_done_s)
    else $error("access not completed after one wait cycle");
  read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_wait_s ##1 (bus_done_s and (avs_read && avs_address[4])) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_done_s and (avs_write && avs_address == REG_CTRL && avs_byteenable[0]))
    |=> management_port_indicator_en_q == $past(avs_writedata[CTRL_MANAGEMENT_PORT_INDICATOR_EN_BIT]))
    else $error("control write lost");
  management_port_indicator_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !management_port_indicator_en_q ##1 !management_port_indicator_en_q |-> !management_port_indicator)
    else $error("management lamp lit while disabled");
  management_port_indicator_solid_a: assert property (@(posedge clk) disable iff (!rst_b)
    management_port_indicator_en_q && leds_en_q && management_port_indicator_link_seen && !management_port_indicator_act_held |=> management_port_indicator)
    else $error("management lamp not solid on idle link");
  management_port_indicator_blink_a: assert property (@(posedge clk) disable iff (!rst_b)
    management_port_indicator_act_held && !blink_phase_q |=> !management_port_indicator)
    else $error("management lamp not blinking on traffic");
  console_led_a: assert property (@(posedge clk) disable iff (!rst_b)
    leds_en_q && cons_sync_q |=> console_led_green)
    else $error("console lamp not lit while console active");
  blink_period_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(blink_phase_q) |-> $past(blink_cnt_q) == 32'(BLINK_HALF_CYCLES - 1))
    else $error("blink phase toggled off period");
  tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    stretch_tick_q |=> !stretch_tick_q || STRETCH_CYCLES == 1)
    else $error("stretch tick longer than one cycle");
endmodule

/* pld_port_model.sv */
// Far-side status logic: drives link, speed, activity and device levels
// just after a rising edge, as real port logic would.
module pld_port_model
  import pld_pkg::*;
(
  // Clock
  input  wire logic                        clk,
  // Port status
  output logic [pld_pkg::NUM_PORTS-1:0]    port_link,
  output logic [pld_pkg::NUM_PORTS-1:0]    port_act,
  output logic [2*pld_pkg::NUM_PORTS-1:0]  port_speed,
  // Device status
  output logic                             management_port_indicator_link,
  output logic                             management_port_indicator_act,
  output logic                             console_active
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    port_link      = '0;
    port_act       = '0;
    port_speed     = '1;
    management_port_indicator_link      = 1'b0;
    management_port_indicator_act       = 1'b0;
    console_active = 1'b0;
  end

  // A port without link shows a meaningless speed code, so the lamp must
  // not lean on the speed pins alone.
  task automatic set_port(input int p, input logic l, input logic [1:0] s);
    @(posedge clk);
    port_link[p]        <= l;
    port_speed[2*p +: 2] <= l ? s : ~s;
  endtask

  task automatic hold_act(input int p, input int n);
    @(posedge clk);
    port_act[p] <= 1'b1;
    repeat (n) @(posedge clk);
    port_act[p] <= 1'b0;
  endtask

  task automatic set_dev(input logic l, input logic a, input logic c);
    @(posedge clk);
    management_port_indicator_link      <= l;
    management_port_indicator_act       <= a;
    console_active <= c;
  endtask
endmodule

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pld_pkg::*;

  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic [4:0]              avs_address = '0;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = '0;
  logic [3:0]              avs_byteenable = 4'hf;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [NUM_PORTS-1:0]    port_link, port_act, port_led_green, port_led_amber;
  logic [2*NUM_PORTS-1:0]  port_speed;
  logic                    management_port_indicator_link, management_port_indicator_act, console_active;
  logic                    management_port_indicator, console_led_green;
  logic [31:0]             rd;
  logic [NUM_PORTS-1:0]    eg, ea;
  int                      errors = 0;
  int                      total_checks = 0;
  int                      c;
  int                      pt[4] = '{0, NUM_GE, NUM_GE + NUM_XG, NUM_GE + NUM_XG + NUM_SFP};
  logic [3:0]              gm[4] = '{GE_GREEN, XG_GREEN, SFP_GREEN, SFPP_GREEN};
  logic [3:0]              am[4] = '{GE_AMBER, XG_AMBER, SFP_AMBER, SFPP_AMBER};

  always #2 clk = ~clk;

  pld_panel_led #(.BLINK_HALF_CYCLES(16), .STRETCH_CYCLES(8)) dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_link(port_link), .port_act(port_act),
    .port_speed(port_speed), .management_port_indicator_link(management_port_indicator_link), .management_port_indicator_act(management_port_indicator_act),
    .console_active(console_active), .port_led_green(port_led_green),
    .port_led_amber(port_led_amber),
    .management_port_indicator(management_port_indicator),
    .console_led_green(console_led_green));

  pld_port_model far (
    .clk(clk), .port_link(port_link), .port_act(port_act), .port_speed(port_speed),
    .management_port_indicator_link(management_port_indicator_link), .management_port_indicator_act(management_port_indicator_act), .console_active(console_active));

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access starts just after an edge and is held until waitrequest is
  // seen low at an edge; one idle edge follows so requests never merge.
  task automatic bus_cycle(input logic [4:0] a, input logic wr, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic count_on(input int n, input bit mg, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      k += mg ? (management_port_indicator === 1'b1) : (port_led_green[0] === 1'b1);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus_cycle(REG_CTRL, 1'b0, '0, 4'hf, rd);
    check(rd, 32'h3);
    bus_cycle(5'h10, 1'b0, '0, 4'hf, rd);
    check(rd, 32'h0);
    // An address that aliases the control word if bit 4 were ignored.
    bus_cycle(5'h10, 1'b1, 32'h0, 4'hf, rd);
    bus_cycle(REG_CTRL, 1'b0, '0, 4'hf, rd);
    check(rd, 32'h3);
    bus_cycle(REG_LINK, 1'b0, '0, 4'hf, rd);
    check(rd, 32'h0);
    check(32'(port_led_green | port_led_amber), 32'h0);
    // Every speed code on one port of each kind, all lamps compared at once.
    for (int t = 0; t < 4; t++) begin
      for (int s = 0; s < 4; s++) begin
        far.set_port(pt[t], 1'b1, 2'(s));
        repeat (6) @(posedge clk);
        eg = gm[t][s] ? (30'(1) << pt[t]) : '0;
        ea = am[t][s] ? (30'(1) << pt[t]) : '0;
        check(32'(port_led_green), 32'(eg));
        check(32'(port_led_amber), 32'(ea));
      end
      far.set_port(pt[t], 1'b0, 2'h2);
      repeat (6) @(posedge clk);
      check(32'(port_led_green | port_led_amber), 32'h0);
    end
    // Activity blinks the lamp; idle returns it to solid.
    far.set_port(0, 1'b1, SPEED_1G);
    fork
      far.hold_act(0, 60);
      begin
        repeat (8) @(posedge clk);
        count_on(48, 1'b0, c);
        check(32'(c > 0 && c < 48), 32'h1);
      end
    join
    repeat (48) @(posedge clk);
    count_on(32, 1'b0, c);
    check(32'(c), 32'd32);
    // A one-cycle pulse is stretched and then expires.
    far.set_port(1, 1'b1, SPEED_1G);
    far.hold_act(1, 1);
    repeat (4) @(posedge clk);
    bus_cycle(REG_ACT, 1'b0, '0, 4'hf, rd);
    check(rd & 32'h2, 32'h2);
    repeat (60) @(posedge clk);
    bus_cycle(REG_ACT, 1'b0, '0, 4'hf, rd);
    check(rd, 32'h0);
    // Management and console lamps.
    far.set_dev(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge clk);
    count_on(32, 1'b1, c);
    check(32'(c), 32'd32);
    check(32'(console_led_green), 32'h1);
    bus_cycle(REG_DEV, 1'b0, '0, 4'hf, rd);
    check(rd & 32'h7, 32'h7);
    far.set_dev(1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    count_on(48, 1'b1, c);
    check(32'(c > 0 && c < 48), 32'h1);
    bus_cycle(REG_CTRL, 1'b1, 32'h2, 4'hf, rd);
    far.set_dev(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    check(32'(management_port_indicator), 32'h0);
    check(32'(console_led_green), 32'h0);
    bus_cycle(REG_CTRL, 1'b1, 32'h3, 4'he, rd);
    repeat (4) @(posedge clk);
    check(32'(management_port_indicator), 32'h0);
    bus_cycle(REG_CTRL, 1'b1, 32'h3, 4'hf, rd);
    // Margin lets the stretched activity of the last burst expire first.
    repeat (8) @(posedge clk);
    check(32'(management_port_indicator), 32'h1);
    far.set_dev(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    check(32'(management_port_indicator), 32'h0);
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule
